// ===== readout_indicator_driver_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
	$display("BAD t=%0t %h %h", $time, a, b); end end
module readout_indicator_driver_tb_top;
	import rid_pkg::*;
	logic clk = 0, rst_b = 0, clk_en = 1, indicator_clear = 0, warmup_delay = 0, error_clear = 0;
	logic low_volt_transient = 0, high_volt_transient = 0, readout_activate, error_lamp_q;
	rid_req_s req;
	rid_sign_s sign_lamps_q;
	logic [15:1][9:0] digit_lamps_q;
	logic [15:1] point_lamps_q;
	logic [3:0] lat [16];
	int error_cnt = 0, samples_checked = 0, cyc = 0, seed;
	rid_host host (.clk(clk), .req(req), .readout_activate(readout_activate));
	rid_readout dut (.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .req(req),
		.readout_activate(readout_activate), .indicator_clear(indicator_clear),
		.warmup_delay(warmup_delay), .low_volt_transient(low_volt_transient),
		.high_volt_transient(high_volt_transient), .error_clear(error_clear),
		.sign_lamps_q(sign_lamps_q), .digit_lamps_q(digit_lamps_q),
		.point_lamps_q(point_lamps_q), .error_lamp_q(error_lamp_q));
	// clock and hang guard
	initial forever #5 clk = ~clk;
	always @(posedge clk) if (++cyc > 5000) begin
		error_cnt++;
		end_of_test();
	end
	task automatic end_of_test;
		if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	function automatic logic [9:0] dig(logic [3:0] c);
		return (c < 4'hA) ? 10'h1 << c : 10'h0;
	endfunction
	function automatic rid_sign_s sgn(logic [3:0] l);
		return '{!l[2] && l[0], !l[2] && !l[0], {l[3], l[1]} == RID_FMT_CMD,
			{l[3], l[1]} == RID_FMT_DEC, {l[3], l[1]} == RID_FMT_OCT};
	endfunction
	// load one position and track its latch
	task automatic ld(logic [3:0] s, logic [3:0] d, logic [2:0] f, bit last);
		host.send('{s, d, f[2], f[1], f[0]}, last);
		if (s == RID_SEL_SIGN) lat[0] = {f[2], d[2], f[1], d[0]};
		else if (s == RID_SEL_SIGNDEC && f[0]) lat[8] = {3'h0, d[0]};
		else lat[s] = d;
	endtask
	task automatic chk;
		for (int p = 1; p < 16; p++) begin
			`CHK(digit_lamps_q[p], dig(lat[p]))
			`CHK(point_lamps_q[p], lat[p] == RID_CODE_POINT)
		end
		`CHK(sign_lamps_q, sgn(lat[0]))
	endtask
	// main sequence
	initial begin
		seed = 32'h3AC0;
		foreach (lat[i]) lat[i] = RID_DRV_RESET;
		repeat (4) @(posedge clk);
		#1 rst_b = 1;
		chk();
		`CHK(error_lamp_q, 1'b0)
		for (int i = 0; i < 16; i++) begin
			ld(4'(i), 4'(i), 3'h0, 0);
			ld(4'(15 - i), 4'(15 - i), 3'h1, 1);
			chk();
		end
		for (int i = 0; i < 4; i++) begin
			ld(4'h0, 4'(i), {2'(i), 1'b0}, 1);
			chk();
		end
		repeat (150) begin
			ld(4'($random(seed)), 4'($random(seed)), 3'($random(seed)), 1);
			chk();
		end
		clk_en = 0;
		host.send('{4'h3, 4'h2, 1'b0, 1'b0, 1'b0}, 1);
		clk_en = 1;
		chk();
		indicator_clear = 1;
		host.send('{4'h5, 4'h4, 1'b0, 1'b0, 1'b0}, 1);
		indicator_clear = 0;
		foreach (lat[i]) lat[i] = RID_DRV_RESET;
		chk();
		warmup_delay = 1;
		low_volt_transient = 1;
		repeat (2) @(posedge clk);
		#1 `CHK(error_lamp_q, 1'b0)
		warmup_delay = 0;
		@(posedge clk);
		#1 low_volt_transient = 0;
		repeat (3) @(posedge clk);
		#1 `CHK(error_lamp_q, 1'b1)
		error_clear = 1;
		@(posedge clk);
		#1 error_clear = 0;
		`CHK(error_lamp_q, 1'b0)
		high_volt_transient = 1;
		@(posedge clk);
		#1 high_volt_transient = 0;
		`CHK(error_lamp_q, 1'b1)
		// transient and operator clear in one cycle: the transient wins
		error_clear = 1;
		low_volt_transient = 1;
		@(posedge clk);
		#1 low_volt_transient = 0;
		`CHK(error_lamp_q, 1'b1)
		@(posedge clk);
		#1 error_clear = 0;
		`CHK(error_lamp_q, 1'b0)
		end_of_test();
	end
endmodule // readout_indicator_driver_tb_top

// ===== rid_driver.sv
`timescale 1ns/1ps
// one position driver: four state flip-flops plus decoding matrix
module rid_driver
	import rid_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        clk_en,
	input  wire logic        load,
	input  wire logic        clear,
	input  wire logic [3:0]  load_val,
	output logic      [3:0]  ff_q,
	output logic      [9:0]  digit_q,
	output logic             point_q
);
	typedef struct packed {
		logic [3:0] ff;
		logic [9:0] digit;
		logic       point;
	} rid_drv_s;

	rid_drv_s st_q;
	rid_drv_s st_d;
	logic [3:0] nxt;

	// next flip-flop value, then decode from it so lamps follow the latch
	always_comb begin
		nxt = st_q.ff;
		if (clear) begin
			nxt = RID_DRV_RESET; // RQ14
		end else if (load) begin
			nxt = load_val; // RQ9
		end
		st_d = st_q;
		st_d.ff = nxt; // RQ5
		// one and-term per element, at most one element lit
		for (int i = 0; i < RID_DIGITS; i++) begin
			st_d.digit[i] = (nxt == 4'(i)); // RQ10
		end
		st_d.point = (nxt == RID_CODE_POINT); // RQ8
	end

	// state register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '{ff: RID_DRV_RESET, digit: 10'h000, point: 1'b0};
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign ff_q    = st_q.ff;
	assign digit_q = st_q.digit;
	assign point_q = st_q.point;
endmodule // rid_driver

// ===== rid_host.sv
`timescale 1ns/1ps
// computer side: one request per clock edge while activate is held high
module rid_host
	import rid_pkg::*;
(
	input  wire logic clk,
	output rid_req_s  req,
	output logic      readout_activate
);
	initial begin
		req = '0;
		readout_activate = 1'b0;
	end
	// fields held over the sampling edge, scrambled once released
	task automatic send(input rid_req_s r, input bit last);
		if (!readout_activate) begin
			@(posedge clk);
			#1;
		end
		req = r;
		readout_activate = 1'b1;
		@(posedge clk);
		#1;
		if (last) begin
			readout_activate = 1'b0;
			req = ~r;
		end
	endtask
endmodule // rid_host

// ===== rid_pkg.sv
package rid_pkg;
	// position count and code widths
	localparam int          RID_POSITIONS   = 16;
	localparam int          RID_SEL_W       = 4;
	localparam int          RID_CODE_W      = 4;
	localparam int          RID_DIGITS      = 10;
	// select code of the sign-and-format position and the sign-forced decade
	localparam logic [3:0]  RID_SEL_SIGN    = 4'h0;
	localparam logic [3:0]  RID_SEL_SIGNDEC = 4'h8;
	// digit code values
	localparam logic [3:0]  RID_CODE_POINT  = 4'hA;
	localparam logic [3:0]  RID_CODE_BLANK  = 4'hD;
	localparam logic [3:0]  RID_CODE_RESET  = 4'hF;
	// reset value of every driver: all flip-flops at one
	localparam logic [3:0]  RID_DRV_RESET   = 4'hF;
	// field positions inside a driver latch (flip-flop n holds bit n-1)
	localparam int          RID_FF1         = 0;
	localparam int          RID_FF2         = 1;
	localparam int          RID_FF3         = 2;
	localparam int          RID_FF4         = 3;
	// format code values
	localparam logic [1:0]  RID_FMT_CMD     = 2'h0;
	localparam logic [1:0]  RID_FMT_OCT     = 2'h1;
	localparam logic [1:0]  RID_FMT_DEC     = 2'h2;

	// one readout request from the computer side
	typedef struct packed {
		logic [3:0] sel;
		logic [3:0] digit;
		logic       fmt_hi;
		logic       fmt_lo;
		logic       sign_force;
	} rid_req_s;

	// lamps of the sign-and-format position
	typedef struct packed {
		logic plus;
		logic minus;
		logic command;
		logic decimal;
		logic octal;
	} rid_sign_s;
endpackage

// ===== rid_readout.sv
`timescale 1ns/1ps
// Operation
// [RQ1] sixteen positions: sign/format group plus fifteen digit-and-point positions
// [RQ2] sign/format position has plus, minus, command, decimal, octal lamps
// [RQ3] every position has its own four-flip-flop driver and and-term decoder
// [RQ4] activate triggers only the driver addressed by the select code
// [RQ5] a triggered driver holds its value until reloaded or cleared
// [RQ6] select 0000 is sign/format, 0001-0110 decades 1-6, 1000-1111 decades 8-15
// [RQ7] select 0111 addresses decade seven
// [RQ8] codes 0-9 light digits, 1010 point, 1101 and 1111 blank
// [RQ9] flip-flop n takes digit code bit n on triggering
// [RQ10] decoder lights exactly the element of the latched code
// [RQ11] sign position: bits 3,1 = 01 plus, 00 minus, bit3 set blanks
// [RQ12] format bits go to flip-flops four and two: 00 C, 01 O, 10 D
// [RQ13] sign force on decade eight zeroes flip-flops 2-4, loads flip-flop one
// [RQ14] indicator clear sets all flip-flops of all drivers to one
// [RQ15] warmup delay holds the transient error flag and lamp off
// [RQ16] without transients the error flag and lamp stay off
// [RQ17] low or high voltage transient sets error flag and lamp
// [RQ18] error flag stays set until operator error clear; here warmup delay also clears it
// [RQ19] request fields held stable and sampled on the activate clock edge
module rid_readout
	import rid_pkg::*;
(
	input  wire logic                      clk,
	input  wire logic                      rst_b,
	input  wire logic                      clk_en,
	input  wire rid_req_s                  req,
	input  wire logic                      readout_activate,
	input  wire logic                      indicator_clear,
	input  wire logic                      warmup_delay,
	input  wire logic                      low_volt_transient,
	input  wire logic                      high_volt_transient,
	input  wire logic                      error_clear,
	output rid_sign_s                      sign_lamps_q,
	output logic [RID_POSITIONS-1:1][9:0]  digit_lamps_q,
	output logic [RID_POSITIONS-1:1]       point_lamps_q,
	output logic                           error_lamp_q
);
	typedef struct packed {
		rid_sign_s sign;
		logic      err;
	} rid_top_s;

	rid_top_s                      st_q;
	rid_top_s                      st_d;
	logic [RID_POSITIONS-1:0]      hit;
	logic [RID_POSITIONS-1:0][3:0] ff;
	logic [3:0]                    digit_val;
	logic [3:0]                    sign_val;
	logic [3:0]                    force_val;
	logic [3:0]                    sign_nxt;

	// address decode, full four-bit compare so 0111 is decade seven
	always_comb begin
		for (int p = 0; p < RID_POSITIONS; p++) begin
			hit[p] = readout_activate && (req.sel == 4'(p)); // RQ4 RQ6 RQ7 RQ19
		end
	end

	// load values for digit, sign-force and sign/format positions
	always_comb begin
		digit_val = req.digit; // RQ9
		force_val = 4'h0; // RQ13
		force_val[RID_FF1] = req.digit[RID_FF1]; // RQ13
		sign_val = 4'h0;
		sign_val[RID_FF1] = req.digit[RID_FF1]; // RQ11
		sign_val[RID_FF3] = req.digit[RID_FF3]; // RQ11
		sign_val[RID_FF4] = req.fmt_hi; // RQ12
		sign_val[RID_FF2] = req.fmt_lo; // RQ12
	end

	// one driver per position
	genvar g;
	generate
		for (g = 0; g < RID_POSITIONS; g++) begin : g_pos
			logic [3:0] lv;
			logic [9:0] dg;
			logic       pt;
			if (g == 0) begin : g_sign
				assign lv = sign_val;
			end else if (g == int'(RID_SEL_SIGNDEC)) begin : g_force
				assign lv = req.sign_force ? force_val : digit_val; // RQ13
			end else begin : g_dig
				assign lv = digit_val;
			end
			rid_driver u_drv ( // RQ3 RQ1
				.clk      (clk),
				.rst_b    (rst_b),
				.clk_en   (clk_en),
				.load     (hit[g]),
				.clear    (indicator_clear),
				.load_val (lv),
				.ff_q     (ff[g]),
				.digit_q  (dg),
				.point_q  (pt)
			);
			if (g > 0) begin : g_out
				assign digit_lamps_q[g] = dg;
				assign point_lamps_q[g] = pt;
			end
		end
	endgenerate

	// predicted next latch of sign driver, so lamps stay registered and in step
	always_comb begin
		sign_nxt = ff[0];
		if (indicator_clear) begin
			sign_nxt = RID_DRV_RESET;
		end else if (hit[0]) begin
			sign_nxt = sign_val;
		end
	end

	// sign/format decode and transient error flag
	always_comb begin
		st_d = st_q;
		st_d.sign.plus    = !sign_nxt[RID_FF3] && sign_nxt[RID_FF1]; // RQ11 RQ2
		st_d.sign.minus   = !sign_nxt[RID_FF3] && !sign_nxt[RID_FF1]; // RQ11
		st_d.sign.command = {sign_nxt[RID_FF4], sign_nxt[RID_FF2]} == RID_FMT_CMD; // RQ12
		st_d.sign.octal   = {sign_nxt[RID_FF4], sign_nxt[RID_FF2]} == RID_FMT_OCT; // RQ12
		st_d.sign.decimal = {sign_nxt[RID_FF4], sign_nxt[RID_FF2]} == RID_FMT_DEC; // RQ12
		// warmup dominates, then a transient beats a concurrent clear
		if (warmup_delay) begin
			st_d.err = 1'b0; // RQ15
		end else if (low_volt_transient || high_volt_transient) begin
			st_d.err = 1'b1; // RQ17
		end else if (error_clear) begin
			st_d.err = 1'b0; // RQ18
		end // else holds: RQ16 RQ18
	end

	// state register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= '0;
		end else if (clk_en) begin
			st_q <= st_d;
		end
	end

	assign sign_lamps_q = st_q.sign;
	assign error_lamp_q = st_q.err;
endmodule // rid_readout

// ===== rid_readout_monitor.sv
`timescale 1ns/1ps
// lamps against activate, clear and transient inputs
module rid_readout_monitor
	import rid_pkg::*;
(
	input wire logic                           clk,
	input wire logic                           rst_b,
	input wire logic                           clk_en,
	input wire logic                           readout_activate,
	input wire logic                           indicator_clear,
	input wire logic                           error_clear,
	input wire logic                           warmup_delay,
	input wire logic                           low_volt_transient,
	input wire logic                           high_volt_transient,
	input wire logic                           error_lamp_q,
	input wire rid_req_s                       req,
	input wire rid_sign_s                      sign_lamps_q,
	input wire logic [RID_POSITIONS-1:1][9:0]  digit_lamps_q,
	input wire logic [RID_POSITIONS-1:1]       point_lamps_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// either transient detector firing
	wire logic tr = low_volt_transient || high_volt_transient;
	// a taken request
	sequence s_load;
		readout_activate && clk_en && !indicator_clear;
	endsequence
	a_err_warm: assert property (warmup_delay && clk_en |=> !error_lamp_q)
		else $error("error lamp lit in warmup");
	a_err_set: assert property (tr && !warmup_delay && clk_en |=> error_lamp_q)
		else $error("transient missed");
	a_err_hold: assert property (
		error_lamp_q && !error_clear && !warmup_delay |=> error_lamp_q)
		else $error("error flag lost");
	a_err_clear: assert property (error_clear && !tr && clk_en |=> !error_lamp_q)
		else $error("error flag not cleared");
	a_clr_dark: assert property (indicator_clear && clk_en |=>
		digit_lamps_q == '0 && point_lamps_q == '0 && sign_lamps_q == '0)
		else $error("clear left lamp");
	a_lamp_hold: assert property (!readout_activate && !indicator_clear |=>
		$stable(digit_lamps_q) && $stable(point_lamps_q) && $stable(sign_lamps_q))
		else $error("lamp drift");
	a_digit_load: assert property (
		s_load ##0 (req.sel != 0 && !req.sign_force && req.digit < 4'hA)
		|=> digit_lamps_q[$past(req.sel)] == 10'h1 << $past(req.digit))
		else $error("digit wrong");
	a_point_load: assert property (
		s_load ##0 (req.sel != 0 && !req.sign_force && req.digit == RID_CODE_POINT)
		|=> point_lamps_q[$past(req.sel)] && digit_lamps_q[$past(req.sel)] == '0)
		else $error("point lamp wrong");
	a_sign_force: assert property (s_load ##0 (req.sel == RID_SEL_SIGNDEC && req.sign_force)
		|=> digit_lamps_q[8] == 10'h1 << $past(req.digit[0])) else $error("sign digit wrong");
	a_sign_lamp: assert property (s_load ##0 (req.sel == 0 && !req.digit[2]) |=>
		sign_lamps_q.plus == $past(req.digit[0]) && sign_lamps_q.minus != $past(req.digit[0]))
		else $error("sign lamp wrong");
	a_fmt_lamp: assert property (
		s_load ##0 (req.sel == 0 && {req.fmt_hi, req.fmt_lo} == RID_FMT_CMD)
		|=> sign_lamps_q.command && !sign_lamps_q.octal && !sign_lamps_q.decimal)
		else $error("format lamp wrong");
endmodule // rid_readout_monitor
bind rid_readout rid_readout_monitor u_mon (.clk(clk), .rst_b(rst_b), .clk_en(clk_en),
	.readout_activate(readout_activate), .indicator_clear(indicator_clear),
	.error_clear(error_clear), .warmup_delay(warmup_delay), .req(req),
	.low_volt_transient(low_volt_transient), .high_volt_transient(high_volt_transient),
	.error_lamp_q(error_lamp_q), .sign_lamps_q(sign_lamps_q),
	.digit_lamps_q(digit_lamps_q), .point_lamps_q(point_lamps_q));
